// ### src/gdma_top.sv
// Two-channel byte copy engine with AXI4-Lite registers
// Function
// RQ1: Two independent channels, each with own addresses, control, enable and done flag.
// RQ2: Channels copy memory bytes to peripheral data registers; no paced service for I2C.
// RQ3: Channels block-copy between memory and flash with programmed addresses and count.
// RQ4: Writing one to control bit 31 starts; hardware clears it when copy ends.
// RQ5: Finishing a copy sets that channel's done flag.
// RQ6: Step field bits 30:29; 00 increments both addresses, 01 decrements both.
// RQ7: Step 10 holds source fixed; 11 holds destination fixed.
// RQ8: Byte count in control bits 23:0, resets to zero, sets copy length.
// RQ9: Per-channel 32-bit read-write source start address, reset zero.
// RQ10: Per-channel 32-bit read-write destination start address, reset zero.
// RQ11: Interrupt word: done0 bit0, enable0 bit1, done1 bit2, enable1 bit3; read clears.
// RQ12: Software programs transmit destination, payload, source and count before starting.
// RQ13: A started transmit channel copies all bytes as one batch, then signals done.
// RQ14: Software programs receive source, buffer destination and count as buffer depth.
// RQ15: In receive, each byte-received event moves exactly one byte.
// RQ16: In receive, done is raised after each received byte is copied.
// RQ17: Interrupt output high while any done flag and its enable are both set.
// RQ18: Non-fixed addresses step one per byte; remaining count falls one per byte.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module gdma_top import gdma_pkg::*; #(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [7:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   output logic rd_req_out,
   output logic [31:0] rd_addr_out,
   input wire logic rd_ready_in,
   input wire logic rd_valid_in,
   input wire logic [7:0] rd_data_in,
   output logic wr_req_out,
   output logic [31:0] wr_addr_out,
   output logic [7:0] wr_data_out,
   input wire logic wr_ready_in,
   input wire logic [1:0] rx_event_in,
   output logic irq_out
);
   // ==========================================================================
   // Declarations
   logic [31:0] source_base [2];
   logic [31:0] dest_base [2];
   logic [1:0] mode [2];
   logic [CNT_W-1:0] cnt [2];
   logic [1:0] busy, paced, done_flag, done_irq_enable;
   logic [1:0] done_clr, done_set, busy_clr, ctrl_we;
   logic [1:0] pend, rx_sync, rx_prev, rx_pulse;
   logic aw_held, w_held, do_write, ar_fire, next_hit;
   logic [7:0] aw_addr;
   logic [31:0] w_data, next_rdata, cur_src, cur_dst;
   logic [3:0] w_strb;
   gdma_state_e state;
   logic act, rd_wait, start_any, start_ch, rd_fire, wr_fire, last_wr;
   logic [CNT_W-1:0] rd_left, wr_left;
   gdma_fifo_if #(.W(8)) fill_if ();
   gdma_fifo_if #(.W(8)) drain_if ();
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================================
   // AXI4-Lite write channel
   assign awready_out = !aw_held;
   assign wready_out = !w_held;
   assign do_write = aw_held & w_held & !bvalid_out;

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= RST_WORD;
         w_strb <= 4'h0;
      end else begin
         if (awvalid_in && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr_in;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (wvalid_in && !w_held) begin
            w_held <= 1'b1;
            w_data <= wdata_in;
            w_strb <= wstrb_in;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bvalid_out <= 1'b0;
         bresp_out <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_out <= 1'b1;
         bresp_out <= (aw_addr <= OFS_IRQ && aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_in) begin
         bvalid_out <= 1'b0;
      end
   end

   // ==========================================================================
   // AXI4-Lite read channel
   assign arready_out = !rvalid_out;
   assign ar_fire = arvalid_in & !rvalid_out;

   always_comb begin
      next_hit = 1'b1;
      next_rdata = RST_WORD;
      unique case (araddr_in)
         OFS_CH0_SRC: next_rdata = source_base[0];
         OFS_CH0_DST: next_rdata = dest_base[0];
         OFS_CH0_CTRL: next_rdata = {busy[0], mode[0], paced[0], 4'h0, cnt[0]};
         OFS_CH1_SRC: next_rdata = source_base[1];
         OFS_CH1_DST: next_rdata = dest_base[1];
         OFS_CH1_CTRL: next_rdata = {busy[1], mode[1], paced[1], 4'h0, cnt[1]};
         OFS_IRQ: next_rdata = {28'h0, done_irq_enable[1], done_flag[1], done_irq_enable[0], done_flag[0]};
         default: next_hit = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rvalid_out <= 1'b0;
         rdata_out <= RST_WORD;
         rresp_out <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_out <= 1'b1;
         rdata_out <= next_rdata;
         rresp_out <= next_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready_in) begin
         rvalid_out <= 1'b0;
      end
   end

   // ==========================================================================
   // Channel registers
   assign ctrl_we[0] = do_write && aw_addr == OFS_CH0_CTRL && !busy[0];
   assign ctrl_we[1] = do_write && aw_addr == OFS_CH1_CTRL && !busy[1];
   assign done_clr = (ar_fire && araddr_in == OFS_IRQ) ? 2'h3 : 2'h0; // RQ11

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int c = 0; c < 2; c++) begin
            source_base[c] <= RST_WORD;
            dest_base[c] <= RST_WORD;
         end
      end else if (do_write) begin
         if (aw_addr == OFS_CH0_SRC) source_base[0] <= merge(source_base[0], w_data, w_strb); // RQ9
         if (aw_addr == OFS_CH1_SRC) source_base[1] <= merge(source_base[1], w_data, w_strb); // RQ9
         if (aw_addr == OFS_CH0_DST) dest_base[0] <= merge(dest_base[0], w_data, w_strb); // RQ10
         if (aw_addr == OFS_CH1_DST) dest_base[1] <= merge(dest_base[1], w_data, w_strb); // RQ10
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int c = 0; c < 2; c++) begin
            busy[c] <= 1'b0;
            mode[c] <= MODE_INC;
            paced[c] <= 1'b0;
            cnt[c] <= RST_CNT;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (ctrl_we[c]) begin
               logic [31:0] v;
               v = merge({busy[c], mode[c], paced[c], 4'h0, cnt[c]}, w_data, w_strb);
               busy[c] <= v[BUSY_BIT]; // RQ4
               mode[c] <= v[MODE_HI:MODE_LO]; // RQ6
               paced[c] <= v[PACED_BIT];
               cnt[c] <= v[CNT_W-1:0]; // RQ8
            end else begin
               if (busy_clr[c]) begin
                  busy[c] <= 1'b0; // RQ4
               end
               if (wr_fire && act == c) begin
                  cnt[c] <= cnt[c] - CNT_W'(1); // RQ18
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         done_flag <= 2'h0;
         done_irq_enable <= 2'h0;
         irq_out <= 1'b0;
      end else begin
         done_flag <= (done_flag & ~done_clr) | done_set; // RQ11
         if (do_write && aw_addr == OFS_IRQ && w_strb[0]) begin
            done_irq_enable <= {w_data[EN1_BIT], w_data[EN0_BIT]}; // RQ11
         end
         irq_out <= |(done_flag & done_irq_enable); // RQ17
      end
   end

   // ==========================================================================
   // Receive event pacing
   gdma_sync3 #(.W(2)) u_rx_sync (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .d_in(rx_event_in),
      .q_out(rx_sync)
   );

   assign rx_pulse = rx_sync & ~rx_prev;

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_prev <= 2'h0;
         pend <= 2'h0;
      end else begin
         rx_prev <= rx_sync;
         for (int c = 0; c < 2; c++) begin
            if (rx_pulse[c]) begin
               pend[c] <= 1'b1; // RQ15
            end else if (rd_fire && act == c) begin
               pend[c] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================================
   // Copy engine
   assign start_any = (state == ST_IDLE) && (busy != 2'h0); // RQ1
   assign start_ch = !busy[0];
   assign rd_req_out = (state == ST_RUN) && rd_left != RST_CNT && !rd_wait && fill_if.ready
      && (!paced[act] || pend[act]); // RQ15
   assign rd_addr_out = cur_src;
   assign rd_fire = rd_req_out & rd_ready_in;
   assign fill_if.valid = rd_valid_in & rd_wait;
   assign fill_if.data = rd_data_in;
   assign wr_req_out = (state == ST_RUN) && drain_if.valid; // RQ2 RQ3
   assign wr_addr_out = cur_dst;
   assign wr_data_out = drain_if.data;
   assign drain_if.ready = (state == ST_RUN) && wr_ready_in;
   assign wr_fire = wr_req_out & wr_ready_in;
   assign last_wr = wr_fire && wr_left == CNT_W'(1);

   always_comb begin
      busy_clr = 2'h0;
      done_set = 2'h0;
      if (start_any && cnt[start_ch] == RST_CNT) begin
         busy_clr[start_ch] = 1'b1;
         done_set[start_ch] = 1'b1;
      end
      if (last_wr) begin
         busy_clr[act] = 1'b1; // RQ4 RQ13
         done_set[act] = 1'b1; // RQ5
      end else if (wr_fire && paced[act]) begin
         done_set[act] = 1'b1; // RQ16
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= ST_IDLE;
         act <= 1'b0;
         cur_src <= RST_WORD;
         cur_dst <= RST_WORD;
         rd_left <= RST_CNT;
         wr_left <= RST_CNT;
         rd_wait <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start_any && cnt[start_ch] != RST_CNT) begin
                  state <= ST_RUN;
                  act <= start_ch;
                  cur_src <= source_base[start_ch]; // RQ9
                  cur_dst <= dest_base[start_ch]; // RQ10
                  rd_left <= cnt[start_ch]; // RQ8
                  wr_left <= cnt[start_ch];
               end
            end
            ST_RUN: begin
               if (rd_fire) begin
                  rd_wait <= 1'b1;
                  cur_src <= gdma_step(cur_src, mode[act], 1'b1); // RQ6 RQ7 RQ18
                  rd_left <= rd_left - CNT_W'(1);
               end else if (fill_if.valid) begin
                  rd_wait <= 1'b0;
               end
               if (wr_fire) begin
                  cur_dst <= gdma_step(cur_dst, mode[act], 1'b0); // RQ6 RQ7 RQ18
                  wr_left <= wr_left - CNT_W'(1);
               end
               if (last_wr) begin
                  state <= ST_IDLE; // RQ13
               end
            end
         endcase
      end
   end

   gdma_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .fill(fill_if.snk),
      .drain(drain_if.src)
   );

   // ==========================================================================
   // Checks
   chk_busy_done_end: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RQ4
      (last_wr && !act) |=> (!busy[0] && done_flag[0] && state == ST_IDLE))
      else $error("channel 0 did not finish cleanly");
   chk_irq_follows: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RQ17
      (|(done_flag & done_irq_enable)) |=> irq_out)
      else $error("interrupt output missing");
   chk_inc_step: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RQ6
      (rd_fire && mode[act] == MODE_INC) |=> cur_src == $past(cur_src) + 32'h1)
      else $error("source did not increment");
   chk_dec_step: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RQ6
      (wr_fire && mode[act] == MODE_DEC) |=> cur_dst == $past(cur_dst) - 32'h1)
      else $error("destination did not decrement");
   chk_src_fixed: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RQ7
      (rd_fire && mode[act] == MODE_SRC_FIX) |=> $stable(cur_src))
      else $error("fixed source moved");
   chk_count_fall: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RQ18
      (wr_fire && !act && !ctrl_we[0]) |=> cnt[0] == $past(cnt[0]) - CNT_W'(1))
      else $error("remaining count did not fall");
   chk_paced_gate: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RQ15
      (rd_fire && paced[act] && !rx_pulse[act]) |=> !pend[act])
      else $error("paced event used for more than one byte");
   chk_rx_done: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RQ16
      (wr_fire && paced[act]) |=> done_flag[act])
      else $error("receive byte did not raise done");
   chk_start_load: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RQ9
      (state == ST_IDLE ##1 state == ST_RUN) |-> (cur_src == source_base[act] && wr_left == cnt[act]))
      else $error("start did not load channel");
   chk_read_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RQ11
      (done_clr[0] && !done_set[0]) |=> !done_flag[0])
      else $error("done flag not cleared by read");
endmodule

// ### src/gdma_pkg.sv
// Shared constants, types and helpers for the two-channel byte copy engine
package gdma_pkg;

   // ==========================================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CH0_SRC = 8'h00;
   localparam logic [7:0] OFS_CH0_DST = 8'h04;
   localparam logic [7:0] OFS_CH0_CTRL = 8'h08;
   localparam logic [7:0] OFS_CH1_SRC = 8'h0C;
   localparam logic [7:0] OFS_CH1_DST = 8'h10;
   localparam logic [7:0] OFS_CH1_CTRL = 8'h14;
   localparam logic [7:0] OFS_IRQ = 8'h18;

   // ==========================================================================
   // Field positions and reset values
   localparam int BUSY_BIT = 31;
   localparam int MODE_HI = 30;
   localparam int MODE_LO = 29;
   localparam int PACED_BIT = 28;
   localparam int CNT_W = 24;
   localparam int DONE0_BIT = 0;
   localparam int EN0_BIT = 1;
   localparam int DONE1_BIT = 2;
   localparam int EN1_BIT = 3;
   localparam logic [31:0] RST_WORD = 32'h0;
   localparam logic [CNT_W-1:0] RST_CNT = 24'h0;
   localparam int FIFO_DEPTH_DEF = 16;

   // ==========================================================================
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_INC = 2'b00,
      MODE_DEC = 2'b01,
      MODE_SRC_FIX = 2'b10,
      MODE_DST_FIX = 2'b11
   } gdma_mode_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } gdma_state_e;

   // Next address of one side for a given stepping mode
   function automatic logic [31:0] gdma_step(input logic [31:0] a, input logic [1:0] m, input logic is_src);
      logic [31:0] r;
      r = a;
      unique case (m)
         MODE_INC: r = a + 32'h1;
         MODE_DEC: r = a - 32'h1;
         MODE_SRC_FIX: r = is_src ? a : a + 32'h1;
         MODE_DST_FIX: r = is_src ? a + 32'h1 : a;
      endcase
      return r;
   endfunction

endpackage

// ### src/gdma_fifo_if.sv
// Valid/ready byte stream between the engine and its data buffer
`timescale 1ns/100ps
interface gdma_fifo_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ### src/gdma_sync3.sv
// Three-stage input filter for signals from outside the clock domain
`timescale 1ns/100ps
module gdma_sync3 #(
   parameter int W = 2
) (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // ==========================================================================
   // Capture and filter
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= d_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q_out <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               q_out[i] <= s2[i];
            end
         end
      end
   end
endmodule

// ### src/gdma_fifo.sv
// Parameterised valid/ready FIFO for the copied bytes
`timescale 1ns/100ps
module gdma_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   gdma_fifo_if.snk fill,
   gdma_fifo_if.src drain
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign fill.ready = (count != (AW+1)'(DEPTH));
   assign drain.valid = (count != '0);
   assign drain.data = mem[rptr];
   assign push = fill.valid & fill.ready;
   assign pop = drain.valid & drain.ready;

   // ==========================================================================
   // Storage
   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem[wptr] <= fill.data;
      end
   end

   // ==========================================================================
   // Pointers and fill level
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
         end
         if (pop) begin
            rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ### verif/gdma_mem_model.sv
// Behavioural byte memory with random stalls on the copy engine's far side
`timescale 1ns/100ps
module gdma_mem_model (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic rd_req_in,
   input wire logic [31:0] rd_addr_in,
   output logic rd_ready_out = 1'b0,
   output logic rd_valid_out = 1'b0,
   output logic [7:0] rd_data_out = 8'hA5,
   input wire logic wr_req_in,
   output logic wr_ready_out = 1'b0,
   input wire logic stall_in
);
   // ==========================================
   // One read in flight, random ready and latency
   integer seed = 32'h7104;
   logic [31:0] r;
   logic [31:0] paddr;
   logic pend = 1'b0;
   logic [1:0] lat = 2'h0;
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_ready_out <= 1'b0;
         rd_valid_out <= 1'b0;
         wr_ready_out <= 1'b0;
         pend = 1'b0;
      end else begin
         r = $random(seed);
         if (pend && lat == 2'h0) begin
            rd_valid_out <= 1'b1;
            rd_data_out <= paddr[7:0] ^ paddr[15:8] ^ 8'h3C;
            pend = 1'b0;
         end else begin
            // Data line keeps toggling outside a return
            rd_valid_out <= 1'b0;
            rd_data_out <= ~rd_data_out;
            lat = lat - 2'h1;
         end
         if (rd_req_in && rd_ready_out) begin
            pend = 1'b1;
            paddr = rd_addr_in;
            lat = r[1:0];
         end
         rd_ready_out <= r[2] | r[3];
         wr_ready_out <= !stall_in && (r[4] | r[5]);
      end
   end
endmodule

// ### verif/tb_two_channel_general_dma.sv
// Self-checking bench for the two-channel byte copy engine
`timescale 1ns/100ps
module tb_two_channel_general_dma import gdma_pkg::*; ;
   localparam int DEPTH = 16;
   logic ref_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] awaddr_in = 8'h0, araddr_in = 8'h0;
   logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0, arvalid_in = 1'b0, rready_in = 1'b0;
   logic stall = 1'b0;
   logic [31:0] wdata_in = 32'h0;
   logic [3:0] wstrb_in = 4'hF;
   logic [1:0] rx_event_in = 2'h0;
   logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, rd_req_out, rd_ready_in;
   logic rd_valid_in, wr_req_out, wr_ready_in, irq_out;
   logic [1:0] bresp_out, rresp_out;
   logic [31:0] rdata_out, rd_addr_out, wr_addr_out;
   logic [7:0] rd_data_in, wr_data_out;
   integer seed = 32'h7104;
   int num_errors = 0, n_compared = 0, n_rd = 0, cyc = 0;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [39:0] wq[$];

   gdma_top #(.FIFO_DEPTH(DEPTH)) i_dut (.ref_clk_in, .rst_b_in, .awaddr_in, .awvalid_in, .awready_out,
      .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in, .araddr_in,
      .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in, .rd_req_out, .rd_addr_out,
      .rd_ready_in, .rd_valid_in, .rd_data_in, .wr_req_out, .wr_addr_out, .wr_data_out, .wr_ready_in,
      .rx_event_in, .irq_out);
   gdma_mem_model i_mem (.ref_clk_in, .rst_b_in, .rd_req_in(rd_req_out), .rd_addr_in(rd_addr_out),
      .rd_ready_out(rd_ready_in), .rd_valid_out(rd_valid_in), .rd_data_out(rd_data_in),
      .wr_req_in(wr_req_out), .wr_ready_out(wr_ready_in), .stall_in(stall));

   // ==========================================
   // Checking helpers and bus tasks
   initial forever #2 ref_clk_in = ~ref_clk_in;
   task automatic cmp(input string what, input logic [39:0] e, input logic [39:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] mem_byte(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction
   always @(posedge ref_clk_in) begin
      cyc++;
      if (rvalid_out && rready_in) cmp("read", rq.pop_front(), {rresp_out, rdata_out});
      if (bvalid_out && bready_in) cmp("bresp", bq.pop_front(), bresp_out);
      if (wr_req_out && wr_ready_in) cmp("mem write", wq.pop_front(), {wr_addr_out, wr_data_out});
      if (rd_req_out && rd_ready_in) n_rd++;
      if (cyc == 40000) begin
         num_errors++;
         final_report();
      end
   end
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge ref_clk_in);
      bq.push_back(er);
      awaddr_in <= a;
      wdata_in <= d;
      awvalid_in <= 1'b1;
      wvalid_in <= 1'b1;
      bready_in <= 1'b1;
      do begin
         @(posedge ref_clk_in);
         if (awready_out) awvalid_in <= 1'b0;
         if (wready_out) wvalid_in <= 1'b0;
      end while (bvalid_out !== 1'b1);
      bready_in <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, input logic [33:0] e);
      @(posedge ref_clk_in);
      rq.push_back(e);
      araddr_in <= a;
      arvalid_in <= 1'b1;
      rready_in <= 1'b1;
      do begin
         @(posedge ref_clk_in);
         if (arready_out) arvalid_in <= 1'b0;
      end while (rvalid_out !== 1'b1);
      rready_in <= 1'b0;
   endtask
   task automatic wait_irq();
      do @(posedge ref_clk_in);
      while (irq_out !== 1'b1);
   endtask

   // ==========================================
   // Scenarios
   task automatic batch(input logic ch, input logic [1:0] m, input int n, input logic stl);
      logic [7:0] b;
      logic [31:0] s, d, i, si, di;
      b = ch ? OFS_CH1_SRC : OFS_CH0_SRC;
      s = $random(seed);
      d = $random(seed);
      for (i = 0; i < n; i++) begin
         si = m == MODE_SRC_FIX ? 32'h0 : m == MODE_DEC ? -i : i;
         di = m == MODE_DST_FIX ? 32'h0 : m == MODE_DEC ? -i : i;
         wq.push_back({d + di, mem_byte(s + si)});
      end
      axw(b, s, RESP_OKAY);
      axw(b + 8'h4, d, RESP_OKAY);
      axr(b, {2'b0, s});
      axr(b + 8'h4, {2'b0, d});
      stall <= stl;
      n_rd = 0;
      axw(b + 8'h8, {1'b1, m, 5'h0, n[23:0]}, RESP_OKAY);
      if (stl) begin
         repeat (200) @(posedge ref_clk_in);
         cmp("reads while stalled", DEPTH, n_rd);
         stall <= 1'b0;
      end
      wait_irq();
      cmp("writes left", 0, wq.size());
      axr(OFS_IRQ, {2'b0, 32'hA | (ch ? 32'h4 : 32'h1)});
      axr(OFS_IRQ, 34'hA);
      axr(b + 8'h8, {3'b0, m, 29'h0});
      cmp("irq line", 0, irq_out);
      $display("test copy ch%0d mode %0d count %0d done", ch, m, n);
   endtask
   task automatic paced();
      logic [31:0] s, d;
      s = $random(seed);
      d = $random(seed);
      for (int k = 0; k < 3; k++) wq.push_back({d + k, mem_byte(s)});
      axw(OFS_CH1_SRC, s, RESP_OKAY);
      axw(OFS_CH1_DST, d, RESP_OKAY);
      axw(OFS_CH1_CTRL, 32'hD000_0003, RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         repeat (30) @(posedge ref_clk_in);
         cmp("bytes before event", 3 - k, wq.size());
         rx_event_in <= 2'b10;
         repeat (6) @(posedge ref_clk_in);
         rx_event_in <= 2'b00;
         wait_irq();
         cmp("bytes after event", 2 - k, wq.size());
         axr(OFS_IRQ, 34'hE);
         if (k == 0) begin
            axw(OFS_CH1_CTRL, 32'h0, RESP_OKAY);
            axr(OFS_CH1_CTRL, 34'hD000_0002);
         end
      end
      axr(OFS_CH1_CTRL, 34'h5000_0000);
      $display("test paced receive done");
   endtask
   initial begin
      repeat (12) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      for (int a = 0; a < 8; a++) axr(8'(4 * a), a == 7 ? {RESP_SLVERR, 32'h0} : 34'h0);
      axw(8'h1C, 32'h1, RESP_SLVERR);
      axw(OFS_IRQ, 32'hA, RESP_OKAY);
      axr(OFS_IRQ, 34'hA);
      axw(OFS_CH0_CTRL, 32'h8000_0000, RESP_OKAY);
      wait_irq();
      axr(OFS_IRQ, 34'hB);
      axr(OFS_CH0_CTRL, 34'h0);
      $display("test reset values done");
      for (int c = 0; c < 2; c++) begin
         for (int m = 0; m < 4; m++) begin
            batch(c[0], m[1:0], 1 + int'({$random(seed)} % 20), 1'b0);
         end
      end
      batch(1'b0, MODE_INC, 24, 1'b1);
      paced();
      final_report();
   end
endmodule
